// ===== rtl/atpc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 8-bit register port, 8 analog channels, 4 dedicated trigger inputs
// Notes: Register fields are laid out by the packed structs below
//
// Operation
// - Writing any of the three control registers aborts the sequence, starts none.
// - The three control registers are readable and writable at any time.
// - Wrap field, bits 2-0 of register zero, sets last channel in multi-channel mode.
// - Wrap codes 1-7 select channels 1-7; code 0 is reserved.
// - Register one bit 7 selects analog pin (0) or dedicated input (1) trigger.
// - Channel field picks pins 0-7, or inputs 0-3; top-bit codes reserved.
// - Without dedicated inputs the source bit is only stored; pin stays source.
// - Register two bit 7 powers converter down (0) or up (1).
// - Fast clear off: status read then result read clears that flag.
// - Fast clear on: any result register access clears its flag.
// - Bit 5 set halts and powers down the converter in wait mode.
// - Leaving wait with bit 5 set resumes conversion; first result is suspect.
// - Bit 4 selects level or edge sensitivity of the external trigger.
// - Bit 3 selects trigger polarity together with the sensitivity bit.
// - Bit 2 disables or enables external triggering.
// - Analog pin as trigger source gets its digital input buffer enabled while bit 2 is set.
// - Sensitivity/polarity: 00 fall, 01 rise, 10 low, 11 high.
// - Bit 0 reads sequence-complete when bit 1 set, else zero; read only.

package atpc_pkg;

  // ==========================================================
  // Sizes
  localparam int ATPC_DW = 8;
  localparam int ATPC_AW = 8;
  localparam int ATPC_NCH = 8;
  localparam int ATPC_NDED = 4;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ATPC_OFS_WRAP = 8'h00;
  localparam logic [7:0] ATPC_OFS_TRIG = 8'h01;
  localparam logic [7:0] ATPC_OFS_CTRL = 8'h02;
  localparam logic [7:0] ATPC_OFS_STAT1 = 8'h03;
  localparam logic [7:0] ATPC_OFS_RES_BASE = 8'h10;
  localparam logic [4:0] ATPC_RES_PAGE = 5'h02;

  // ==========================================================
  // Reset values
  localparam logic [7:0] ATPC_RST_WRAP = 8'h07;
  localparam logic [7:0] ATPC_RST_TRIG = 8'h00;
  localparam logic [7:0] ATPC_RST_CTRL = 8'h00;

  // ==========================================================
  // Register layouts, bit 7 first
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] wrap_chan;
  } atpc_wrap_reg_t;

  typedef struct packed {
    logic src_dedicated;
    logic [3:0] rsvd;
    logic [2:0] chan;
  } atpc_trig_reg_t;

  typedef struct packed {
    logic power_on;
    logic fast_clear;
    logic wait_pd;
    logic level_sel;
    logic polarity;
    logic trig_en;
    logic irq_en;
    logic irq_flag;
  } atpc_ctrl_reg_t;

  // Sensitivity decode
  typedef enum logic [1:0] {
    ATPC_FALLING,
    ATPC_RISING,
    ATPC_LOW,
    ATPC_HIGH
  } atpc_sens_t;

  // Settings handed to the sequencer and analog core
  typedef struct packed {
    logic power_up;
    logic halt;
    logic fast_clear;
    logic [2:0] wrap_chan;
  } atpc_cfg_t;

endpackage

// ===== rtl/atpc_trig_detect.sv
// Purpose: Synchronise and qualify the selected external trigger
// Assumes: Trigger is already multiplexed to one bit
// Notes: Start is a single-cycle pulse

`timescale 1ns/10ps

module atpc_trig_detect
  import atpc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic trig_raw_i,
  input wire logic enable_i,
  input wire logic level_sel_i,
  input wire logic polarity_i,
  output logic start_o,
  output logic level_hold_o
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic en_q;
  atpc_sens_t sens;
  logic rise;
  logic fall;
  logic act_now;
  logic act_prev;

  // ==========================================================
  // Two-stage synchroniser
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      sync1_q <= trig_raw_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      en_q <= enable_i;
    end
  end

  // ==========================================================
  // Detection
  assign sens = atpc_sens_t'({level_sel_i, polarity_i});
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign act_now = (sync2_q == polarity_i);
  assign act_prev = (prev_q == polarity_i) & en_q;

  always_comb begin
    start_o = 1'b0;
    level_hold_o = 1'b0;
    if (enable_i) begin
      case (sens)
        ATPC_FALLING: start_o = fall;
        ATPC_RISING: start_o = rise;
        default: begin
          start_o = act_now & ~act_prev;
          level_hold_o = act_now;
        end
      endcase
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_edge_single_start: assert property (
    (enable_i && !level_sel_i && start_o) |=> !start_o)
    else $error("edge trigger started twice in a row");

  a_rise_needs_edge: assert property (
    (enable_i && sens == ATPC_RISING && start_o) |-> (!$past(sync2_q) && sync2_q))
    else $error("rising start without rising edge");

  a_level_holds: assert property (
    (enable_i && level_sel_i && polarity_i && sync2_q) |-> level_hold_o)
    else $error("high level not held");

endmodule

// ===== rtl/atpc_ccf_flags.sv
// Purpose: Conversion-complete flags with normal and fast clearing
// Assumes: Set pulses come from the sequencer
// Notes: A set in the clearing cycle wins

`timescale 1ns/10ps

module atpc_ccf_flags
  import atpc_pkg::*;
#(
  parameter int NCH = ATPC_NCH
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [NCH-1:0] set_i,
  input wire logic stat_rd_i,
  input wire logic res_rd_i,
  input wire logic res_wr_i,
  input wire logic [$clog2(NCH)-1:0] res_idx_i,
  input wire logic fast_i,
  output logic [NCH-1:0] flags_o
);

  localparam int CW = $clog2(NCH);

  logic [NCH-1:0] flag_q;
  logic [NCH-1:0] armed_q;
  logic [NCH-1:0] clr;

  // ==========================================================
  // Per-flag clear logic
  for (genvar i = 0; i < NCH; i++) begin : g_flag
    logic hit;
    assign hit = (res_idx_i == CW'(i));
    assign clr[i] = fast_i ? (hit & (res_rd_i | res_wr_i))
                           : (hit & res_rd_i & armed_q[i]);
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        flag_q[i] <= 1'b0;
        armed_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= set_i[i] | (flag_q[i] & ~clr[i]);
        if (stat_rd_i) begin
          armed_q[i] <= flag_q[i];
        end else if (clr[i] | set_i[i]) begin
          armed_q[i] <= 1'b0;
        end
      end
    end
  end

  assign flags_o = flag_q;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_res_read_0;
    res_rd_i && res_idx_i == '0 && !set_i[0];
  endsequence

  sequence s_stat_then_read_0;
    stat_rd_i && flag_q[0] && !fast_i ##1 (!stat_rd_i && !set_i[0]) ##1 s_res_read_0;
  endsequence

  a_normal_clear: assert property (
    (s_stat_then_read_0 ##0 !fast_i) |=> !flag_q[0])
    else $error("flag not cleared after status then result read");

  a_normal_keeps: assert property (
    (!fast_i && res_rd_i && res_idx_i == '0 && flag_q[0] && !armed_q[0]) |=> flag_q[0])
    else $error("flag cleared without prior status read");

  a_fast_clear: assert property (
    (fast_i && res_wr_i && res_idx_i == '0 && !set_i[0]) |=> !flag_q[0])
    else $error("fast clear on result access failed");

endmodule

// ===== rtl/atpc_control.sv
// Purpose: Control registers for trigger, power and wrap of the converter
// Assumes: Register port strobes are one cycle, never both at once
// Notes: Result data for read-back come from the result store outside

`timescale 1ns/10ps

module atpc_control
  import atpc_pkg::*;
#(
  parameter int NCH = ATPC_NCH,
  parameter int NDED = ATPC_NDED,
  parameter bit HAS_DED_TRIG = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [ATPC_AW-1:0] addr_i,
  input wire logic [ATPC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ATPC_DW-1:0] rdata_o,
  input wire logic [NCH-1:0] ccf_set_i,
  input wire logic seq_complete_i,
  input wire logic [NCH-1:0][ATPC_DW-1:0] result_data_i,
  input wire logic wait_mode_i,
  input wire logic [NCH-1:0] analog_din_i,
  input wire logic [NDED-1:0] ded_trig_i,
  output logic abort_seq_o,
  output logic ext_start_o,
  output logic ext_level_o,
  output logic [NCH-1:0] dig_in_en_o,
  output logic resume_o,
  output logic discard_next_o,
  output atpc_cfg_t cfg_o
);

  localparam int CW = $clog2(NCH);

  // ==========================================================
  // Address decode
  logic hit_wrap;
  logic hit_trig;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_res;
  logic hit_any_ctrl;
  logic [CW-1:0] res_idx;

  assign hit_wrap = (addr_i == ATPC_OFS_WRAP);
  assign hit_trig = (addr_i == ATPC_OFS_TRIG);
  assign hit_ctrl = (addr_i == ATPC_OFS_CTRL);
  assign hit_stat = (addr_i == ATPC_OFS_STAT1);
  assign hit_res = (addr_i[7:3] == ATPC_RES_PAGE);
  assign res_idx = addr_i[CW-1:0];
  assign hit_any_ctrl = hit_wrap | hit_trig | hit_ctrl;

  // ==========================================================
  // Control registers
  atpc_wrap_reg_t wrap_q;
  atpc_trig_reg_t trig_q;
  atpc_ctrl_reg_t ctrl_q;
  logic abort_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wrap_q <= atpc_wrap_reg_t'(ATPC_RST_WRAP);
      trig_q <= atpc_trig_reg_t'(ATPC_RST_TRIG);
      ctrl_q <= atpc_ctrl_reg_t'(ATPC_RST_CTRL);
    end else if (wr_i) begin
      if (hit_wrap) begin
        wrap_q.wrap_chan <= wdata_i[2:0];
      end else if (hit_trig) begin
        trig_q.src_dedicated <= wdata_i[7];
        trig_q.chan <= wdata_i[2:0];
      end else if (hit_ctrl) begin
        ctrl_q[7:1] <= wdata_i[7:1];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= wr_i & hit_any_ctrl;
    end
  end

  assign abort_seq_o = abort_q;

  // ==========================================================
  // Conversion-complete flags
  logic [NCH-1:0] ccf_flags;

  atpc_ccf_flags #(
    .NCH(NCH)
  ) u_flags (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(ccf_set_i),
    .stat_rd_i(rd_i & hit_stat),
    .res_rd_i(rd_i & hit_res),
    .res_wr_i(wr_i & hit_res),
    .res_idx_i(res_idx),
    .fast_i(ctrl_q.fast_clear),
    .flags_o(ccf_flags)
  );

  // ==========================================================
  // Read path
  logic irq_flag_rd;
  logic [ATPC_DW-1:0] rd_mux;
  logic [ATPC_DW-1:0] rdata_q;

  assign irq_flag_rd = ctrl_q.irq_en & seq_complete_i;

  always_comb begin
    rd_mux = '0;
    if (hit_wrap) begin
      rd_mux = {5'h00, wrap_q.wrap_chan};
    end else if (hit_trig) begin
      rd_mux = {trig_q.src_dedicated, 4'h0, trig_q.chan};
    end else if (hit_ctrl) begin
      rd_mux = {ctrl_q[7:1], irq_flag_rd};
    end else if (hit_stat) begin
      rd_mux = ATPC_DW'(ccf_flags);
    end else if (hit_res) begin
      rd_mux = result_data_i[res_idx];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (rd_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

  // ==========================================================
  // Trigger source selection
  logic use_ded;
  logic src_reserved;
  logic trig_raw;
  logic trig_armed;

  assign use_ded = HAS_DED_TRIG & trig_q.src_dedicated;
  assign src_reserved = use_ded & trig_q.chan[2];
  assign trig_raw = use_ded ? (~src_reserved & ded_trig_i[trig_q.chan[1:0]])
                            : analog_din_i[trig_q.chan];
  assign trig_armed = ctrl_q.trig_en & ~src_reserved & cfg_o.power_up;

  atpc_trig_detect u_trig (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .trig_raw_i(trig_raw),
    .enable_i(trig_armed),
    .level_sel_i(ctrl_q.level_sel),
    .polarity_i(ctrl_q.polarity),
    .start_o(ext_start_o),
    .level_hold_o(ext_level_o)
  );

  // ==========================================================
  // Digital input buffer enables
  logic [NCH-1:0] din_en_d;
  logic [NCH-1:0] din_en_q;

  for (genvar i = 0; i < NCH; i++) begin : g_din
    assign din_en_d[i] = ctrl_q.trig_en & ~use_ded
                         & (trig_q.chan == 3'(i));
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      din_en_q <= '0;
    end else begin
      din_en_q <= din_en_d;
    end
  end

  assign dig_in_en_o = din_en_q;

  // ==========================================================
  // Power and wait handling
  atpc_cfg_t cfg_d;
  atpc_cfg_t cfg_q;
  logic wait_q;
  logic resume_q;
  logic discard_q;
  logic wait_halt;

  assign wait_halt = wait_mode_i & ctrl_q.wait_pd;
  assign cfg_d.power_up = ctrl_q.power_on & ~wait_halt;
  assign cfg_d.halt = wait_halt;
  assign cfg_d.fast_clear = ctrl_q.fast_clear;
  assign cfg_d.wrap_chan = wrap_q.wrap_chan;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q <= '0;
      wait_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      wait_q <= wait_mode_i;
      resume_q <= wait_q & ~wait_mode_i & ctrl_q.wait_pd;
    end
  end

  // Result after a wake-up is flagged as unreliable
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      discard_q <= 1'b0;
    end else if (resume_q) begin
      discard_q <= 1'b1;
    end else if (|ccf_set_i | abort_q) begin
      discard_q <= 1'b0;
    end
  end

  assign cfg_o = cfg_q;
  assign resume_o = resume_q;
  assign discard_next_o = discard_q;

  // ==========================================================
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ctrl_write;
    wr_i && hit_any_ctrl;
  endsequence

  sequence s_wait_exit;
    wait_mode_i && ctrl_q.wait_pd ##1 !wait_mode_i;
  endsequence

  a_write_aborts: assert property (
    s_ctrl_write |=> abort_seq_o ##1 !abort_seq_o || $past(wr_i && hit_any_ctrl))
    else $error("control write did not abort once");

  a_abort_cause: assert property (
    abort_seq_o |-> $past(wr_i && hit_any_ctrl))
    else $error("abort without control write");

  a_wrap_readback: assert property (
    (wr_i && hit_wrap) ##1 !wr_i ##1 (rd_i && hit_wrap) |=>
      rdata_o == {5'h00, $past(wdata_i[2:0], 3)})
    else $error("wrap field read-back mismatch");

  a_wrap_to_cfg: assert property (
    (wr_i && hit_wrap) |=> ##1 cfg_o.wrap_chan == $past(wdata_i[2:0], 2))
    else $error("wrap channel not forwarded");

  a_irq_mirror: assert property (
    (rd_i && hit_ctrl) |=> rdata_o[0] == $past(ctrl_q.irq_en && seq_complete_i))
    else $error("interrupt flag read wrong");

  a_wait_powerdown: assert property (
    (wait_mode_i && ctrl_q.wait_pd) |=> !cfg_o.power_up && cfg_o.halt)
    else $error("converter not halted in wait");

  a_power_off: assert property (
    !ctrl_q.power_on |=> !cfg_o.power_up)
    else $error("converter powered while bit clear");

  a_resume_pulse: assert property (
    s_wait_exit |=> resume_o ##1 discard_next_o)
    else $error("no resume after wait exit");

  a_din_buffer: assert property (
    (ctrl_q.trig_en && !use_ded && !wr_i) |=> dig_in_en_o == (NCH'(1) << $past(trig_q.chan)))
    else $error("trigger pin buffer not enabled");

  a_ded_no_buffer: assert property (
    (|dig_in_en_o) |-> $past(!use_ded))
    else $error("pin buffer enabled for dedicated source");

  a_rsvd_no_start: assert property (
    src_reserved |-> !trig_armed)
    else $error("reserved source armed");

endmodule

// ===== sim/atpc_trig_src.sv
// Purpose: Far-side trigger sources for the converter control block
// Assumes: One pin is driven by the bench, pins 0-7 analog, 8-11 dedicated
// Notes: Every other pin toggles each cycle so a wrong pick shows up

`timescale 1ns/10ps

module atpc_trig_src
  import atpc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [3:0] sel_i,
  input wire logic level_i,
  output logic [ATPC_NCH-1:0] analog_din_o,
  output logic [ATPC_NDED-1:0] ded_trig_o
);
  logic tog_q = 1'b0;
  logic [15:0] pins_d;

  always @(posedge ref_clk_i) begin
    tog_q <= ~tog_q;
  end

  always_comb begin
    pins_d = {16{tog_q}};
    pins_d[sel_i] = level_i;
  end

  assign analog_din_o = pins_d[7:0];
  assign ded_trig_o = pins_d[11:8];
endmodule

// ===== sim/atpc_control_test.sv
// Purpose: Self-checking bench for the converter control registers
// Assumes: Register port of one-cycle strobes, read data one cycle later
// Notes: Expected values come from bench shadows of the registers

`timescale 1ns/10ps

module atpc_control_test
  import atpc_pkg::*;
;
  logic ref_clk_i, sys_rst_i, wr_i, rd_i, seq_complete_i, wait_mode_i;
  logic [7:0] addr_i, wdata_i, rdata_o, ccf_set_i, analog_din_i, dig_in_en_o;
  logic [3:0] ded_trig_i, src_sel;
  logic [7:0][7:0] result_data_i;
  logic abort_seq_o, ext_start_o, ext_level_o, resume_o, discard_next_o, src_lvl;
  atpc_cfg_t cfg_o;
  int miscompares = 0;
  int total_checks = 0;
  int starts = 0;
  int resumes = 0;
  logic [31:0] seed = 32'h450d3c0e;
  logic [7:0] sh_wrap, sh_trig, sh_ctrl, v, a;

  atpc_control i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ccf_set_i(ccf_set_i),
    .seq_complete_i(seq_complete_i), .result_data_i(result_data_i),
    .wait_mode_i(wait_mode_i), .analog_din_i(analog_din_i), .ded_trig_i(ded_trig_i),
    .abort_seq_o(abort_seq_o), .ext_start_o(ext_start_o), .ext_level_o(ext_level_o),
    .dig_in_en_o(dig_in_en_o), .resume_o(resume_o), .discard_next_o(discard_next_o),
    .cfg_o(cfg_o));

  atpc_trig_src i_src (.ref_clk_i(ref_clk_i), .sel_i(src_sel), .level_i(src_lvl),
    .analog_din_o(analog_din_i), .ded_trig_o(ded_trig_i));

  // ==========================================================
  // Helpers
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (ext_start_o === 1'b1) starts <= starts + 1;
    if (resume_o === 1'b1) resumes <= resumes + 1;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    case (ad)
      8'h00: exp_rd = sh_wrap & 8'h07;
      8'h01: exp_rd = sh_trig & 8'h87;
      8'h02: exp_rd = (sh_ctrl & 8'hfe) | {7'h00, sh_ctrl[1] & seq_complete_i};
      default: exp_rd = 8'h00;
    endcase
  endfunction

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_byte(what, {7'h00, e}, {7'h00, g});
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
    if (ad == 8'h00) sh_wrap = d;
    if (ad == 8'h01) sh_trig = d;
    if (ad == 8'h02) sh_ctrl = d;
    chk_bit("abort", ad < 8'h03, abort_seq_o);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk_byte("rdata", e, rdata_o);
    chk_bit("abort", 1'b0, abort_seq_o);
  endtask

  task automatic pulse_ccf(input int i);
    @(posedge ref_clk_i);
    ccf_set_i <= 8'h01 << i;
    @(posedge ref_clk_i);
    ccf_set_i <= 8'h00;
  endtask

  task automatic trig_case(input logic kind, input logic [2:0] ch, input logic le,
                           input logic pol, input logic en);
    logic ok;
    int s0;
    ok = en & ~(kind & ch[2]);
    @(posedge ref_clk_i);
    src_sel <= kind ? (ch[2] ? 4'hc : {2'b10, ch[1:0]}) : {1'b0, ch};
    src_lvl <= ~pol;
    wr(8'h01, {kind, 4'h0, ch});
    wr(8'h02, {3'b100, le, pol, en, 2'b00});
    repeat (5) @(posedge ref_clk_i);
    s0 = starts;
    src_lvl <= pol;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk_byte("starts", 8'(ok), 8'(starts - s0));
    chk_bit("level", ok & le, ext_level_o);
    if (en) chk_byte("dig_in_en", kind ? 8'h00 : 8'h01 << ch, dig_in_en_o);
    src_lvl <= ~pol;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk_byte("starts", 8'(ok), 8'(starts - s0));
    chk_bit("level", 1'b0, ext_level_o);
  endtask

  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    ccf_set_i = 8'h00;
    seq_complete_i = 1'b1;
    wait_mode_i = 1'b0;
    src_sel = 4'hf;
    src_lvl = 1'b0;
    for (int i = 0; i < 8; i++) result_data_i[i] = 8'(rnd());
    sh_wrap = 8'h07;
    sh_trig = 8'h00;
    sh_ctrl = 8'h00;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) rd(i[7:0], exp_rd(i[7:0]));
    rd(8'h20, 8'h00);
    for (int n = 0; n < 30; n++) begin
      a = 8'(rnd() % 3);
      v = 8'(rnd());
      if (n == 0) begin
        a = 8'h00;
        v = 8'hf9;
      end
      // Reserved wrap code is never written
      if (a == 8'h00 && v[2:0] == 3'h0) v[0] = 1'b1;
      wr(a, v);
      rd(a, exp_rd(a));
      chk_byte("cfg", {2'b00, sh_ctrl[7], 1'b0, sh_ctrl[6], sh_wrap[2:0]}, 8'(cfg_o));
    end
    for (int k = 0; k < 4; k++) trig_case(1'b0, 3'(rnd()), k[1], k[0], 1'b1);
    for (int k = 0; k < 4; k++) trig_case(1'b1, {1'b0, k[1:0]}, k[1], ~k[0], 1'b1);
    trig_case(1'b1, 3'h4, 1'b0, 1'b1, 1'b1);
    trig_case(1'b0, 3'h5, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 8; i += 3) begin
      // Results are read only with external triggering off
      wr(8'h02, 8'h00);
      pulse_ccf(i);
      rd(8'h10 + i[7:0], result_data_i[i]);
      rd(8'h03, 8'h01 << i);
      rd(8'h10 + i[7:0], result_data_i[i]);
      rd(8'h03, 8'h00);
      wr(8'h02, 8'h40);
      pulse_ccf(i);
      wr(8'h10 + i[7:0], 8'h5a);
      rd(8'h03, 8'h00);
      pulse_ccf(i);
      rd(8'h10 + i[7:0], result_data_i[i]);
      rd(8'h03, 8'h00);
    end
    wr(8'h02, 8'ha0);
    wait_mode_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_bit("halt", 1'b1, cfg_o.halt);
    v = 8'(resumes);
    wait_mode_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk_byte("resumes", v + 8'h01, 8'(resumes));
    chk_bit("discard", 1'b1, discard_next_o);
    pulse_ccf(2);
    #1;
    chk_bit("discard", 1'b0, discard_next_o);
    wr(8'h02, 8'h80);
    wait_mode_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_bit("halt", 1'b0, cfg_o.halt);
    wait_mode_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk_byte("resumes", v + 8'h01, 8'(resumes));
    seq_complete_i <= 1'b0;
    wr(8'h02, 8'h03);
    rd(8'h02, 8'h02);
    seq_complete_i <= 1'b1;
    rd(8'h02, 8'h03);
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h00);
    finish_test();
  end
endmodule
